// ===== src/psc_sequencer.v
/*
 * Power sequence controller: programmable step sequencer with four delay
 * timers, step-qualified exceptions and free-running supervisory equations.
 * Assumes the configuration tables are loaded through the cfg port while
 * seq_go is low, and that all inputs are synchronous to clk.
 */
// Operation
// - Exceptions armed only past exception-region marker.
// - Output step changes chosen outputs together.
// - Wait step holds until expression true.
// - Timeout wait ends on expression or expiry.
// - Delay step lasts selected timer's period.
// - Branch picks first target true, second false.
// - Exception applies outputs and jumps to target.
// - Each step selects which exceptions apply.
// - Supervisory equations evaluate continuously, independent.
// - Timeout branch: true, expired, else third; timer untouched.
// - Start runs timer; stop halts and clears.
// - Idle step changes nothing, takes one cycle.
// - Steps past protected marker ignore exceptions.
`include "psc_regs.vh"

module psc_sequencer #(
    parameter [63:0]           TMR_LIMITS = `PSC_TMR_LIM_DEF, // Ticks per timer.
    parameter [`PSC_OUT_W-1:0] OUT_RESET  = 8'h00             // Power-up outputs.
) (
    input  wire                     clk,
    input  wire                     rst,
    input  wire                     seq_go,
    input  wire [`PSC_IN_W-1:0]     in_sig,
    input  wire                     cfg_we,
    input  wire [1:0]               cfg_sel,
    input  wire [`PSC_STEP_W-1:0]   cfg_addr,
    input  wire [`PSC_WORD_W-1:0]   cfg_data,
    output reg  [`PSC_OUT_W-1:0]    out_en_r,
    output reg  [`PSC_STEP_W-1:0]   step_r,
    output reg                      halted_r,
    output reg  [`PSC_N_SUP-1:0]    sup_out_r,
    output wire [`PSC_N_TMR-1:0]    tmr_expired
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration storage.
    reg  [`PSC_WORD_W-1:0] prog_mem [0:(1<<`PSC_STEP_W)-1]; // Program steps.
    reg  [`PSC_WORD_W-1:0] exc_mem  [0:`PSC_N_EXC-1];      // Exception entries.
    reg  [`PSC_WORD_W-1:0] sup_mem  [0:`PSC_N_SUP-1];      // Supervisory entries.
    reg  [`PSC_STEP_W-1:0] exc_idx_r;                      // Exception-region marker.
    reg  [`PSC_STEP_W-1:0] prot_idx_r;                     // Protected-region marker.

    // Sequencer next-state signals.
    reg  [`PSC_STEP_W-1:0] step_nxt;
    reg  [`PSC_OUT_W-1:0]  out_nxt;
    reg                    halt_nxt;
    reg  [`PSC_N_TMR-1:0]  t_start;                        // Timer start pulses.
    reg  [`PSC_N_TMR-1:0]  t_clr;                          // Timer stop-and-clear.
    reg                    exc_take;                       // An exception fires.
    reg  [1:0]             exc_sel;                        // Winning exception.
    reg  [4:0]             pre_r;                          // Timer prescaler.
    wire                   tick = (pre_r == `PSC_TMR_DIV);
    integer                i;

    // Decoded current instruction.
    wire [`PSC_WORD_W-1:0] inst    = prog_mem[step_r];
    wire [3:0]             op      = inst[`PSC_F_OP];
    wire [1:0]             tsel    = inst[`PSC_F_TSEL];
    wire [`PSC_N_TMR-1:0]  tsel_oh = 4'b0001 << tsel;
    wire [`PSC_STEP_W-1:0] step_inc = step_r + 6'h01;
    wire                   expr_ok = psc_expr(in_sig, inst[`PSC_F_A], inst[`PSC_F_B]);
    wire                   t_exp   = tmr_expired[tsel];
    wire [`PSC_WORD_W-1:0] exc_w   = exc_mem[exc_sel];

    // Exceptions are live strictly after the exception-region marker and up
    // to the protected marker; a missing exception-region marker leaves them disarmed.
    wire exc_armed = (exc_idx_r != `PSC_IDX_NONE) && (step_r > exc_idx_r) &&
                     (step_r <= prot_idx_r);

    // A masked compare: true when every masked input equals its match bit.
    // An empty mask is always true, which suits unconditional entries.
    function psc_expr;
        input [`PSC_IN_W-1:0] v;
        input [`PSC_IN_W-1:0] m;
        input [`PSC_IN_W-1:0] p;
        begin
            psc_expr = (((v ^ p) & m) == 8'h00);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration load. Marker positions are snooped as steps are written so
    // the region checks need no scan of the program.
    always @(posedge clk) begin
        if (cfg_we && cfg_sel == `PSC_SEL_PROG) begin
            prog_mem[cfg_addr] <= cfg_data;
        end
        if (cfg_we && cfg_sel == `PSC_SEL_EXC) begin
            exc_mem[cfg_addr[1:0]] <= cfg_data;
        end
        if (cfg_we && cfg_sel == `PSC_SEL_SUP) begin
            sup_mem[cfg_addr[1:0]] <= cfg_data;
        end
    end

    // Marker registers; rewriting the step clears a stale marker.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            exc_idx_r  <= `PSC_IDX_NONE;
            prot_idx_r <= `PSC_IDX_NONE;
        end else if (cfg_we && cfg_sel == `PSC_SEL_PROG) begin
            if (cfg_data[`PSC_F_OP] == `PSC_OP_EXC_MARK) begin
                exc_idx_r <= cfg_addr;
            end else if (cfg_addr == exc_idx_r) begin
                exc_idx_r <= `PSC_IDX_NONE;
            end
            if (cfg_data[`PSC_F_OP] == `PSC_OP_PROT_MARK) begin
                prot_idx_r <= cfg_addr;
            end else if (cfg_addr == prot_idx_r) begin
                prot_idx_r <= `PSC_IDX_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Exception selection: the lowest-numbered true, step-enabled entry wins.
    always @* begin
        exc_take = 1'b0;
        exc_sel  = 2'h0;
        for (i = `PSC_N_EXC - 1; i >= 0; i = i - 1) begin
            if (exc_armed && inst[i] &&
                psc_expr(in_sig, exc_mem[i][`PSC_X_MASK], exc_mem[i][`PSC_X_MATCH])) begin
                exc_take = 1'b1;
                exc_sel  = i[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Step decode. Every step lasts one cycle unless it waits on something.
    always @* begin
        step_nxt = step_r;
        out_nxt  = out_en_r;
        halt_nxt = halted_r;
        t_start  = 4'h0;
        t_clr    = 4'h0;
        if (seq_go && !halted_r) begin
            case (op)
                `PSC_OP_OUTPUT: begin
                    // Turn-on and turn-off masks land in one edge.
                    out_nxt  = (out_en_r | inst[`PSC_F_A]) & ~inst[`PSC_F_B];
                    step_nxt = step_inc;
                end
                `PSC_OP_WAIT: begin
                    if (expr_ok) begin
                        step_nxt = step_inc;
                    end
                end
                `PSC_OP_WAIT_TO: begin
                    // The timer is started on entry and cleared on exit so a
                    // later timeout wait on it begins from a full period.
                    if (expr_ok || t_exp) begin
                        step_nxt = step_inc;
                        t_clr    = tsel_oh;
                    end else begin
                        t_start  = tsel_oh;
                    end
                end
                `PSC_OP_DELAY: begin
                    if (t_exp) begin
                        step_nxt = step_inc;
                        t_clr    = tsel_oh;
                    end else begin
                        t_start  = tsel_oh;
                    end
                end
                `PSC_OP_BRANCH: begin
                    step_nxt = expr_ok ? inst[`PSC_F_TA] : inst[`PSC_F_TB];
                end
                `PSC_OP_BRANCH_TO: begin
                    // Only looks at the timer; never starts or clears it.
                    if (expr_ok) begin
                        step_nxt = inst[`PSC_F_TA];
                    end else if (t_exp) begin
                        step_nxt = inst[`PSC_F_TB];
                    end else begin
                        step_nxt = inst[`PSC_F_TC];
                    end
                end
                `PSC_OP_GOTO: begin
                    step_nxt = inst[`PSC_F_TA];
                end
                `PSC_OP_TSTART: begin
                    t_start  = tsel_oh;
                    step_nxt = step_inc;
                end
                `PSC_OP_TSTOP: begin
                    t_clr    = tsel_oh;
                    step_nxt = step_inc;
                end
                `PSC_OP_HALT: begin
                    halt_nxt = 1'b1;
                end
                default: begin
                    // Idle and both markers: one cycle, nothing else.
                    step_nxt = step_inc;
                end
            endcase
        end
        // An enabled exception overrides the step's outputs, target, halt and timer starts; its timer clears still apply.
        if (seq_go && exc_take) begin
            out_nxt  = (out_en_r | exc_w[`PSC_X_SET]) & ~exc_w[`PSC_X_CLR];
            step_nxt = exc_w[`PSC_X_TGT];
            halt_nxt = 1'b0;
            t_start  = 4'h0;
        end
    end

    // Sequencer state moves only on the rising edge.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            step_r   <= `PSC_STEP_RST;
            out_en_r <= OUT_RESET;
            halted_r <= 1'b0;
        end else begin
            step_r   <= step_nxt;
            out_en_r <= out_nxt;
            halted_r <= halt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer prescaler: the timers count in units of 32 clocks.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_r <= 5'h00;
        end else begin
            pre_r <= tick ? 5'h00 : pre_r + 5'h01;
        end
    end

    // Four identical timers. Clear beats start so a stop is never lost.
    genvar g;
    generate
        for (g = 0; g < `PSC_N_TMR; g = g + 1) begin : gen_tmr
            reg  [`PSC_TMR_CW-1:0] cnt_r;   // Elapsed ticks.
            reg                    run_r;   // Counting.
            reg                    exp_r;   // Period elapsed, held until cleared.
            wire [`PSC_TMR_CW-1:0] lim = TMR_LIMITS[g*`PSC_TMR_CW +: `PSC_TMR_CW];
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    cnt_r <= 16'h0000;
                    run_r <= 1'b0;
                    exp_r <= 1'b0;
                end else if (t_clr[g]) begin
                    cnt_r <= 16'h0000;
                    run_r <= 1'b0;
                    exp_r <= 1'b0;
                end else begin
                    if (t_start[g] && !exp_r) begin
                        run_r <= 1'b1;
                    end
                    if (run_r && tick) begin
                        if (cnt_r >= lim - 16'h0001) begin
                            exp_r <= 1'b1;
                            run_r <= 1'b0;
                        end else begin
                            cnt_r <= cnt_r + 16'h0001;
                        end
                    end
                end
            end
            assign tmr_expired[g] = exp_r;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Supervisory equations run every cycle whatever the step.
    // Follow mode mirrors the expression a cycle late; sticky mode latches a
    // fault until reset, trading recovery for a record of the event.
    generate
        for (g = 0; g < `PSC_N_SUP; g = g + 1) begin : gen_sup
            wire hit = psc_expr(in_sig, sup_mem[g][`PSC_S_MASK], sup_mem[g][`PSC_S_MATCH]);
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    sup_out_r[g] <= 1'b0;
                end else if (sup_mem[g][`PSC_S_STICKY]) begin
                    sup_out_r[g] <= sup_out_r[g] | hit;
                end else begin
                    sup_out_r[g] <= hit;
                end
            end
        end
    endgenerate

endmodule // psc_sequencer

// ===== src/psc_regs.vh
/*
 * Constants for the power sequence controller: widths, configuration word
 * layouts, opcodes, configuration selectors and timing figures.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef PSC_REGS_VH
`define PSC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Widths.
`define PSC_IN_W        8           // Monitored inputs (comparators, pins).
`define PSC_OUT_W       8           // Controlled supply enables.
`define PSC_STEP_W      6           // Step index width, 64 program steps.
`define PSC_WORD_W      48          // Configuration word width.
`define PSC_N_TMR       4           // Delay timers.
`define PSC_N_EXC       4           // Exception equations.
`define PSC_N_SUP       4           // Supervisory equations.

////////////////////////////////////////////////////////////////////////////////
// Program instruction fields.
`define PSC_F_OP        47:44       // Opcode.
`define PSC_F_TSEL      43:42       // Timer select.
`define PSC_F_A         41:34       // Expression mask, or outputs to turn on.
`define PSC_F_B         33:26       // Expression match, or outputs to turn off.
`define PSC_F_TA        25:20       // First target step.
`define PSC_F_TB        19:14       // Second target step.
`define PSC_F_TC        13:8        // Third target step.
`define PSC_F_EXCEN     3:0         // Exceptions enabled in this step.

// Exception entry fields.
`define PSC_X_MASK      47:40
`define PSC_X_MATCH     39:32
`define PSC_X_SET       31:24
`define PSC_X_CLR       23:16
`define PSC_X_TGT       13:8

// Supervisory entry fields.
`define PSC_S_MASK      47:40
`define PSC_S_MATCH     39:32
`define PSC_S_STICKY    0

////////////////////////////////////////////////////////////////////////////////
// Opcodes.
`define PSC_OP_IDLE     4'h0
`define PSC_OP_OUTPUT   4'h1
`define PSC_OP_WAIT     4'h2
`define PSC_OP_WAIT_TO  4'h3
`define PSC_OP_DELAY    4'h4
`define PSC_OP_BRANCH   4'h5
`define PSC_OP_BRANCH_TO 4'h6
`define PSC_OP_GOTO     4'h7
`define PSC_OP_TSTART   4'h8
`define PSC_OP_TSTOP    4'h9
`define PSC_OP_HALT     4'hA
`define PSC_OP_EXC_MARK 4'hB
`define PSC_OP_PROT_MARK 4'hC

// Configuration table selectors.
`define PSC_SEL_PROG    2'h0
`define PSC_SEL_EXC     2'h1
`define PSC_SEL_SUP     2'h2

////////////////////////////////////////////////////////////////////////////////
// Reset values and timing.
`define PSC_STEP_RST    6'h00
`define PSC_IDX_NONE    6'h3F       // Marker index meaning "no marker loaded".
`define PSC_TMR_DIV     5'h1F       // Prescaler terminal count: divide by 32.
`define PSC_TMR_CW      16          // Timer count width.
`define PSC_TMR_LIM_DEF 64'h0010_0040_0100_0400

`endif

// ===== tb/psc_sequencer_props.sv
/* Checker for the sequencer ports; mirrors the program table from cfg writes.
   Assumes programs are loaded with seq_go low and judges steps with excen 0. */
`include "psc_regs.vh"
module psc_sequencer_props #(
    parameter [7:0] OUT_RESET = 8'h00
) (
    input logic        clk,
    input logic        rst,
    input logic        seq_go,
    input logic [7:0]  in_sig,
    input logic        cfg_we,
    input logic [1:0]  cfg_sel,
    input logic [5:0]  cfg_addr,
    input logic [47:0] cfg_data,
    input logic [7:0]  out_en_r,
    input logic [5:0]  step_r,
    input logic        halted_r,
    input logic [3:0]  sup_out_r,
    input logic [3:0]  tmr_expired
);
    timeunit 1ns;
    timeprecision 100ps;
    reg [47:0] pm [0:63];  // Shadow of the program table.
    reg [3:0]  sk;         // Shadow of the supervisory sticky flags.
    // Snoop program and supervisory writes so each entry is known here.
    always @(posedge clk) begin
        if (cfg_we && cfg_sel == `PSC_SEL_PROG) begin
            pm[cfg_addr] <= cfg_data;
        end
        if (cfg_we && cfg_sel == `PSC_SEL_SUP) begin
            sk[cfg_addr[1:0]] <= cfg_data[0];
        end
    end
    wire [47:0] cw  = pm[step_r];                                 // Current word.
    wire [3:0]  op  = cw[47:44];                                  // Current opcode.
    wire        ex  = ((in_sig ^ cw[33:26]) & cw[41:34]) == 8'h00; // Expression.
    wire        tx  = tmr_expired[cw[43:42]];                     // Selected expiry.
    // Exceptions cannot touch a step whose excen is clear, so only those are judged.
    wire        run = seq_go && !halted_r && cw[3:0] == 4'h0;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence dly_hold;
        run && op == `PSC_OP_DELAY && !tx;
    endsequence
    sequence dly_done;
        run && op == `PSC_OP_DELAY && tx;
    endsequence
    reset_home_a: assert property (
        disable iff (1'b0) rst |-> step_r == 6'h00 && out_en_r == OUT_RESET)
        else $error("step or outputs not at home in reset");
    frozen_run_a: assert property (!seq_go |=> $stable(step_r) && $stable(out_en_r))
        else $error("sequencer moved while stopped");
    idle_step_a: assert property (
        run && (op == `PSC_OP_IDLE || op == `PSC_OP_EXC_MARK)
        |=> step_r == $past(step_r) + 6'h01 && $stable(out_en_r))
        else $error("idle step did not advance cleanly");
    output_set_a: assert property (
        run && op == `PSC_OP_OUTPUT
        |=> out_en_r == (($past(out_en_r) | $past(cw[41:34])) & ~$past(cw[33:26])))
        else $error("output step gave wrong enables");
    wait_hold_a: assert property (
        run && op == `PSC_OP_WAIT |=> step_r == $past(step_r) + {5'h00, $past(ex)})
        else $error("wait step moved wrongly");
    wait_timeout_a: assert property (
        run && op == `PSC_OP_WAIT_TO
        |=> step_r == $past(step_r) + {5'h00, $past(ex || tx)})
        else $error("timeout wait moved wrongly");
    delay_hold_a: assert property (dly_hold |=> $stable(step_r))
        else $error("delay ended before expiry");
    delay_done_a: assert property (
        dly_done |=> step_r == $past(step_r) + 6'h01 && !tmr_expired[$past(cw[43:42])])
        else $error("delay did not end on expiry");
    branch_pick_a: assert property (
        run && op == `PSC_OP_BRANCH
        |=> step_r == ($past(ex) ? $past(cw[25:20]) : $past(cw[19:14])))
        else $error("branch took wrong target");
    branch_timeout_a: assert property (
        run && op == `PSC_OP_BRANCH_TO
        |=> step_r == ($past(ex) ? $past(cw[25:20]) :
                       $past(tx) ? $past(cw[19:14]) : $past(cw[13:8])))
        else $error("timeout branch took wrong target");
    timer_stop_a: assert property (
        run && op == `PSC_OP_TSTOP |=> !tmr_expired[$past(cw[43:42])])
        else $error("stopped timer still expired");
    // A sticky supervisory output, once set, must never fall outside reset.
    sticky_keep_a: assert property (
        |(sk & sup_out_r) |=> (sup_out_r & $past(sk & sup_out_r)) == $past(sk & sup_out_r))
        else $error("sticky supervisory output fell");
endmodule // psc_sequencer_props

// ===== tb/psc_supply_model.sv
/* Supply rails: each enabled rail reports good after a settle delay.
   Assumes the bench drives flt to invert chosen status lines. */
module psc_supply_model (
    input  logic       clk,
    input  logic       rst,
    input  logic       slow,
    input  logic [7:0] en,
    input  logic [7:0] flt,
    output logic [7:0] good
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] pg_r;   // Settled rail status.
    logic [3:0] cnt_r;  // Settle counter; slow rails stress wait steps.
    // Rails follow their enables only after the settle time has run out.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pg_r <= 8'h00;
            cnt_r <= 4'h0;
        end else if (pg_r == en) begin
            cnt_r <= 4'h0;
        end else if (cnt_r >= (slow ? 4'h9 : 4'h1)) begin
            pg_r <= en;
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    assign good = pg_r ^ flt;  // Inverted lines model a failing rail.
endmodule // psc_supply_model

// ===== tb/psc_sequencer_tb_top.sv
/* Bench for the sequencer: loads programs, runs scenarios, judges the ports.
   Assumes psc_regs.vh is on the include path. */
`include "psc_regs.vh"
module psc_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, seq_go, cfg_we, slow, halted_r;
    logic [1:0]  cfg_sel;
    logic [5:0]  cfg_addr, step_r;
    logic [47:0] cfg_data;
    logic [7:0]  in_sig, out_en_r, flt;
    logic [3:0]  sup_out_r, tmr_expired;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc = 0;
    psc_sequencer #(.TMR_LIMITS(64'h0002_0003_0004_0005), .OUT_RESET(8'h00)) u_psc_sequencer (
        .clk(clk), .rst(rst), .seq_go(seq_go), .in_sig(in_sig), .cfg_we(cfg_we),
        .cfg_sel(cfg_sel), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .out_en_r(out_en_r),
        .step_r(step_r), .halted_r(halted_r), .sup_out_r(sup_out_r), .tmr_expired(tmr_expired));
    psc_supply_model u_psc_supply_model (.clk(clk), .rst(rst), .slow(slow), .en(out_en_r),
        .flt(flt), .good(in_sig));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // A hang ends the run as a failure.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            give_verdict;
        end
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Holds cfg_we up across a batch; the caller lowers it afterwards.
    task cfg(input logic [1:0] s, input logic [5:0] a, input logic [47:0] d);
        cfg_we <= 1'b1;
        cfg_sel <= s;
        cfg_addr <= a;
        cfg_data <= d;
        @(posedge clk);
    endtask
    function automatic logic [47:0] ins(input logic [3:0] op, input logic [1:0] ts,
        input logic [7:0] a, b, input logic [5:0] ta, tb, tc, input logic [3:0] ex);
        return {op, ts, a, b, ta, tb, tc, 4'h0, ex};
    endfunction
    task do_reset;
        @(posedge clk);
        rst <= 1'b1;
        seq_go <= 1'b0;
        flt <= 8'h00;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask
    // Waits on falling edges so the step register has settled.
    task wait_for(input logic [5:0] s, input int lim);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (step_r !== s && n < lim);
    endtask
    task go;
        cfg_we <= 1'b0;
        seq_go <= 1'b1;
    endtask
    task run_basic;
        do_reset;
        chk("step", step_r, 48'h0);
        chk("outputs", out_en_r, 48'h0);
        slow <= 1'b1;
        cfg(0, 6'h00, ins(`PSC_OP_IDLE, 0, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h01, ins(`PSC_OP_OUTPUT, 0, 8'h0F, 0, 0, 0, 0, 0));
        cfg(0, 6'h02, ins(`PSC_OP_WAIT, 0, 8'h0F, 8'h0F, 0, 0, 0, 0));
        cfg(0, 6'h03, ins(`PSC_OP_OUTPUT, 0, 8'hF0, 8'h03, 0, 0, 0, 0));
        cfg(0, 6'h04, ins(`PSC_OP_HALT, 0, 0, 0, 0, 0, 0, 0));
        go;
        wait_for(6'h02, 20);
        chk("outputs", out_en_r, 48'h0F);
        repeat (3) @(negedge clk);
        chk("step", step_r, 48'h2);
        wait_for(6'h04, 40);
        @(negedge clk);
        chk("outputs", out_en_r, 48'hFC);
        chk("halted", halted_r, 48'h1);
    endtask
    task run_flow;
        do_reset;
        cfg(0, 6'h00, ins(`PSC_OP_TSTART, 1, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h01, ins(`PSC_OP_DELAY, 0, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h02, ins(`PSC_OP_BRANCH, 0, 8'h01, 0, 6'h04, 6'h03, 0, 0));
        cfg(0, 6'h03, ins(`PSC_OP_HALT, 0, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h04, ins(`PSC_OP_BRANCH_TO, 1, 8'h01, 8'h01, 6'h03, 6'h06, 6'h04, 0));
        cfg(0, 6'h06, ins(`PSC_OP_TSTOP, 1, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h07, ins(`PSC_OP_WAIT_TO, 2, 8'h01, 8'h01, 0, 0, 0, 0));
        cfg(0, 6'h08, ins(`PSC_OP_HALT, 0, 0, 0, 0, 0, 0, 0));
        go;
        wait_for(6'h01, 10);
        repeat (100) @(negedge clk);
        chk("step", step_r, 48'h1);
        wait_for(6'h02, 100);
        chk("step", step_r, 48'h2);
        wait_for(6'h08, 600);
        chk("step", step_r, 48'h8);
        chk("expired", tmr_expired[1], 48'h0);
    endtask
    task run_exc;
        do_reset;
        cfg(0, 6'h00, ins(`PSC_OP_OUTPUT, 0, 8'h01, 0, 0, 0, 0, 4'h1));
        cfg(0, 6'h01, ins(`PSC_OP_EXC_MARK, 0, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h02, ins(`PSC_OP_WAIT, 0, 8'h01, 8'h01, 0, 0, 0, 0));
        // Step 3 is released by the very input that fires the exception.
        cfg(0, 6'h03, ins(`PSC_OP_WAIT, 0, 8'h01, 8'h00, 0, 0, 0, 4'h1));
        cfg(0, 6'h05, ins(`PSC_OP_PROT_MARK, 0, 0, 0, 0, 0, 0, 0));
        cfg(0, 6'h06, ins(`PSC_OP_WAIT, 0, 8'h80, 8'h80, 0, 0, 0, 4'h1));
        cfg(1, 6'h00, {8'h01, 8'h00, 8'h00, 8'h01, 2'b00, 6'h05, 8'h00});
        go;
        wait_for(6'h03, 40);
        chk("outputs", out_en_r, 48'h01);
        @(posedge clk);
        flt <= 8'h01;
        wait_for(6'h05, 10);
        chk("step", step_r, 48'h5);
        chk("outputs", out_en_r, 48'h00);
        @(posedge clk);
        flt <= 8'h00;
        repeat (20) @(negedge clk);
        chk("step", step_r, 48'h6);
    endtask
    task run_sup;
        do_reset;
        cfg(2, 6'h00, {8'h01, 8'h01, 32'h0000_0000});
        cfg(2, 6'h01, {8'h02, 8'h02, 32'h0000_0001});
        cfg(2, 6'h02, 48'h0);
        cfg(2, 6'h03, 48'h0);
        cfg_we <= 1'b0;
        flt <= 8'h03;
        repeat (3) @(negedge clk);
        chk("supervisory", sup_out_r, 48'hF);
        @(posedge clk);
        flt <= 8'h00;
        repeat (3) @(negedge clk);
        chk("supervisory", sup_out_r, 48'hE);
    endtask
    initial begin
        // Non-blocking so the async reset processes see the rising edge at time zero.
        rst <= 1'b1;
        seq_go = 1'b0;
        cfg_we = 1'b0;
        cfg_sel = 2'h0;
        cfg_addr = 6'h00;
        cfg_data = 48'h0;
        flt = 8'h00;
        slow = 1'b0;
        run_basic;
        run_flow;
        run_exc;
        run_sup;
        give_verdict;
    end
endmodule // psc_sequencer_tb_top
bind psc_sequencer psc_sequencer_props #(.OUT_RESET(OUT_RESET)) u_psc_sequencer_props (
    .clk(clk), .rst(rst), .seq_go(seq_go), .in_sig(in_sig), .cfg_we(cfg_we),
    .cfg_sel(cfg_sel), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .out_en_r(out_en_r),
    .step_r(step_r), .halted_r(halted_r), .sup_out_r(sup_out_r), .tmr_expired(tmr_expired));
